/* logic/dee_ctrl.sv */
// Data EEPROM write controller: CPU bus side, row latches, timed programming, protection.
// Assumes a synchronous single-cycle CPU bus on mclk and an array that takes one-byte write strobes.
// Protection option and power requests arrive as levels from the system controller.
//
// What this block does
// - With latch access clear, EEPROM reads come straight from the array.
// - In write mode, outside a cycle and without protection, each EEPROM write lands in one of 32 latches by low address.
// - Setting program start walks all captured latched bytes into the array, one per clock.
// - Programming row is the upper address of the most recent accepted EEPROM write.
// - At cycle end program start and latch access clear in the same clock.
// - A second write to a latched byte programs the AND of both values.
// - Latches clear only at cycle end, on latch access falling and in the halt state.
// - Latched, unprogrammed data is never returned on a bus read.
// - Wait or active-halt request waits at once if idle, else after the cycle.
// - Halt stops at once, abandoning any programming in progress.
// - EEPROM reads while latch access is set leave the data bus undriven.
// - EEPROM writes while latch access is clear are ignored entirely.
// - Reset aborts a programming cycle; array contents are then undefined.
// - Read-out protection blocks external read-out and rewriting of the EEPROM.
// - Removing protection while the sequencer is idle first erases whole program memory and whole EEPROM.
// - One option setting governs protection of program memory and EEPROM.
// - The erase-plus-program cycle is timed internally, no software pacing.
// - Clearing latch access is ignored while program start is set.
// - Program start at bit 0 reads one while a cycle runs.
// - Control bits 7 to 2 read zero, bit 1 is latch access, reset zero.
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.svh"

module dee_ctrl
  import dee_pkg::*;
#(
  parameter int unsigned PROG_CYC = `DEE_PROG_CYC,
  parameter int unsigned ERASE_CYC = `DEE_ERASE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_rdata_en_n,
  input wire logic ext_access,
  input wire logic wait_for_interrupt_instr,
  input wire logic active_halt_req,
  input wire logic halt_req,
  input wire logic readout_protect_option,
  input wire logic [7:0] arr_rdata,
  output logic [7:0] arr_addr,
  output logic arr_rd,
  output logic [7:0] arr_wdata,
  output logic arr_wr,
  output logic arr_erase_all,
  output logic prog_mem_erase_all,
  output logic busy,
  output logic eeprom_wait,
  output logic eeprom_halted
);

  // Counter width covers the longest timed operation at the system clock.
  localparam int unsigned CNT_W = 32;

  // Every bus strobe is a single-cycle pulse sampled on the rising clock edge.
  // Read data is registered, so it stands for the one clock after the request edge.
  // Software polls the program start bit to learn that a cycle has finished.
  // A walk abandoned by halt or reset leaves the row partly written.

  // Decoded bus accesses.
  logic in_ee;
  logic csr_sel;
  logic ee_rd;
  logic ee_wr;
  logic csr_wr;
  logic csr_rd;
  assign in_ee = (bus_addr >= `DEE_BASE) && (bus_addr < (`DEE_BASE + `DEE_SIZE));
  assign csr_sel = (bus_addr == `DEE_CSR_ADDR);
  assign ee_rd = bus_rd && in_ee;
  assign ee_wr = bus_wr && in_ee;
  assign csr_wr = bus_wr && csr_sel;
  assign csr_rd = bus_rd && csr_sel;

  // Sequencer state and the two software-visible flags.
  dee_state_t state_r;
  logic latch_mode_flag_r;
  logic program_cycle_flag_r;

  // Row latches, their valid marks and the row taken from the last write.
  logic [7:0] lat_data_r [`DEE_NLAT];
  logic [`DEE_NLAT-1:0] lat_used_r;
  logic [2:0] row_r;

  // Timing counter and walking column; the column top bit marks a finished walk.
  logic [CNT_W-1:0] cnt_r;
  logic [`DEE_COL_W:0] col_r;

  // Protection copy and the marker that one clock has passed since reset.
  logic prot_r;
  logic prot_seen_r;

  // Decoded events used by several processes.
  logic lat_fall;
  logic cycle_end;
  logic sleep_req;
  logic wr_ok;
  logic walk_wr;
  logic [`DEE_COL_W-1:0] walk_col;

  // Writes are accepted only in write mode, not during a cycle, and not under protection.
  assign wr_ok = ee_wr && latch_mode_flag_r && !program_cycle_flag_r && !prot_r;
  assign cycle_end = (state_r == DEE_PROG) && (cnt_r == '0) && col_r[`DEE_COL_W];
  assign sleep_req = wait_for_interrupt_instr || active_halt_req;
  // Latch access drops either by software (only with program start clear) or at cycle end.
  assign lat_fall = latch_mode_flag_r &&
                    ((csr_wr && !bus_wdata[`DEE_LAT_BIT] && !program_cycle_flag_r) || cycle_end);
  // The walk writes one latch per clock until the column top bit sets; halt stops it.
  assign walk_wr = (state_r == DEE_PROG) && !col_r[`DEE_COL_W] && !halt_req;
  assign walk_col = col_r[`DEE_COL_W-1:0];

  // Latch access flag: set by software, cleared at cycle end, in the halt state, or by software when idle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      latch_mode_flag_r <= 1'b0;
    end else if (cycle_end || state_r == DEE_HALT) begin
      latch_mode_flag_r <= 1'b0;
    end else if (csr_wr && !program_cycle_flag_r) begin
      latch_mode_flag_r <= bus_wdata[`DEE_LAT_BIT];
    end
  end

  // Program start flag: set by software in write mode, cleared by hardware at cycle end or in the halt state.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      program_cycle_flag_r <= 1'b0;
    end else if (cycle_end || state_r == DEE_HALT) begin
      program_cycle_flag_r <= 1'b0;
    end else if (csr_wr && bus_wdata[`DEE_PGM_BIT] && latch_mode_flag_r && !prot_r) begin
      program_cycle_flag_r <= 1'b1;
    end
  end

  // Row register follows the upper address of the latest accepted EEPROM write.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      row_r <= 3'h0;
    end else if (wr_ok) begin
      row_r <= bus_addr[7:`DEE_COL_W];
    end
  end

  // Per-entry latches; repeated writes AND into the entry, clears happen together.
  genvar gi;
  generate
    for (gi = 0; gi < `DEE_NLAT; gi++) begin : g_lat
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          lat_data_r[gi] <= 8'hFF;
          lat_used_r[gi] <= 1'b0;
        end else if (lat_fall || state_r == DEE_HALT) begin
          lat_data_r[gi] <= 8'hFF;
          lat_used_r[gi] <= 1'b0;
        end else if (wr_ok && bus_addr[`DEE_COL_W-1:0] == `DEE_COL_W'(gi)) begin
          lat_data_r[gi] <= lat_data_r[gi] & bus_wdata;
          lat_used_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // Protection copy starts protected, so reset never opens a read-out window.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prot_r <= 1'b1;
    end else begin
      prot_r <= readout_protect_option;
    end
  end

  // The first clock after reset only loads the copy; a removal is judged from then on.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prot_seen_r <= 1'b0;
    end else begin
      prot_seen_r <= 1'b1;
    end
  end

  // Sequencer: idle, timed programming walk, erase, wait and halt.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= DEE_IDLE;
      cnt_r <= '0;
      col_r <= '0;
    end else if (halt_req) begin
      state_r <= DEE_HALT;
      cnt_r <= '0;
      col_r <= '0;
    end else begin
      case (state_r)
        DEE_IDLE: begin
          if (prot_seen_r && prot_r && !readout_protect_option) begin
            state_r <= DEE_ERASE;
            cnt_r <= CNT_W'(ERASE_CYC - 1);
          end else if (program_cycle_flag_r) begin
            state_r <= DEE_PROG;
            cnt_r <= CNT_W'(PROG_CYC - 1);
            col_r <= '0;
          end else if (sleep_req) begin
            state_r <= DEE_WAIT;
          end
        end
        DEE_PROG: begin
          if (!col_r[`DEE_COL_W]) begin
            col_r <= col_r + 1'b1; // Walk latches into the array one per clock.
          end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            col_r <= '0;
            state_r <= sleep_req ? DEE_WAIT : DEE_IDLE;
          end
        end
        DEE_ERASE: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            state_r <= DEE_IDLE;
          end
        end
        DEE_WAIT: begin
          if (!sleep_req) begin
            state_r <= DEE_IDLE;
          end
        end
        DEE_HALT: begin
          state_r <= DEE_IDLE;
        end
        default: begin
          state_r <= DEE_IDLE;
        end
      endcase
    end
  end

  // Array write strobe and data: each used latch goes to its row cell during the walk.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arr_wr <= 1'b0;
      arr_wdata <= 8'h00;
    end else if (walk_wr) begin
      arr_wr <= lat_used_r[walk_col];
      arr_wdata <= lat_data_r[walk_col];
    end else begin
      arr_wr <= 1'b0;
    end
  end

  // Array address: row and walking column during the walk, else the CPU address.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arr_addr <= 8'h00;
    end else if (walk_wr) begin
      arr_addr <= {row_r, walk_col};
    end else begin
      arr_addr <= bus_addr[7:0];
    end
  end

  // Array read strobe: only plain reads in read mode reach the cells.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arr_rd <= 1'b0;
    end else begin
      arr_rd <= ee_rd && !latch_mode_flag_r;
    end
  end

  // Array erase strobe, held through the erase state.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arr_erase_all <= 1'b0;
    end else begin
      arr_erase_all <= (state_r == DEE_ERASE);
    end
  end

  // Program memory erase strobe, driven in step with the array erase.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prog_mem_erase_all <= 1'b0;
    end else begin
      prog_mem_erase_all <= (state_r == DEE_ERASE);
    end
  end

  // Busy covers both timed operations, programming and erase.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_r == DEE_PROG) || (state_r == DEE_ERASE);
    end
  end

  // Wait indicator follows the sleep state one clock later.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eeprom_wait <= 1'b0;
    end else begin
      eeprom_wait <= (state_r == DEE_WAIT);
    end
  end

  // Halt indicator follows the halt state one clock later.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eeprom_halted <= 1'b0;
    end else begin
      eeprom_halted <= (state_r == DEE_HALT);
    end
  end

  // Read data: array data or status, one clock after the request; latches are never read.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
      bus_rdata_en_n <= 1'b1;
    end else if (csr_rd) begin
      bus_rdata <= {6'h00, latch_mode_flag_r, program_cycle_flag_r};
      bus_rdata_en_n <= 1'b0;
    end else if (ee_rd && !latch_mode_flag_r && !(prot_r && ext_access)) begin
      bus_rdata <= arr_rdata;
      bus_rdata_en_n <= 1'b0;
    end else begin
      bus_rdata <= 8'h00;
      bus_rdata_en_n <= 1'b1;
    end
  end

endmodule // dee_ctrl
`default_nettype wire

/* shared/dee_consts.svh */
// Constants for the data EEPROM write controller: offsets, field positions, reset values, timing.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DEE_CONSTS_SVH
`define DEE_CONSTS_SVH

// Control/status register address within the peripheral space.
`define DEE_CSR_ADDR 16'h0030
// Field positions inside the control/status register.
`define DEE_PGM_BIT 0
`define DEE_LAT_BIT 1
// Reset value of the control/status register.
`define DEE_CSR_RST 8'h00
// EEPROM window base and size.
`define DEE_BASE 16'h1000
`define DEE_SIZE 16'h0100
// Row geometry: 32 latches, five column bits.
`define DEE_COL_W 5
`define DEE_NLAT 32
// Programming cycle time in microseconds and the derived clock count at 125 MHz.
`define DEE_PROG_US 3000
`define DEE_CLK_MHZ 125
`define DEE_PROG_CYC (`DEE_PROG_US * `DEE_CLK_MHZ)
// Whole-memory erase time on protection removal, in microseconds and cycles.
`define DEE_ERASE_US 100
`define DEE_ERASE_CYC (`DEE_ERASE_US * `DEE_CLK_MHZ)

`endif

/* shared/dee_pkg.sv */
// Types for the data EEPROM write controller.
// Assumes the constants header sits beside it on the include path.
`include "dee_consts.svh"

package dee_pkg;
  // Controller sequencing states.
  typedef enum logic [2:0] {
    DEE_IDLE = 3'b000,
    DEE_PROG = 3'b001,
    DEE_WAIT = 3'b010,
    DEE_HALT = 3'b011,
    DEE_ERASE = 3'b100
  } dee_state_t;
endpackage

/* dv/dee_array_model.sv */
// Behavioural model of the EEPROM cell array behind the controller.
// Assumes read data is looked up at once from the CPU address.
`timescale 1ns/1ps
`default_nettype none
module dee_array_model (
  input wire logic mclk,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] arr_addr,
  input wire logic arr_wr,
  input wire logic [7:0] arr_wdata,
  input wire logic arr_erase_all,
  output logic [7:0] arr_rdata
);
  logic [7:0] mem_r [256];
  // Cells start erased, so a stray erase cannot pass for data.
  initial foreach (mem_r[i]) mem_r[i] = 8'hFF;
  // One byte per write strobe, or the whole array erased.
  always @(posedge mclk) begin
    if (arr_erase_all) foreach (mem_r[i]) mem_r[i] <= 8'hFF;
    else if (arr_wr) mem_r[arr_addr] <= arr_wdata;
  end
  // Read data follows the CPU address without delay.
  assign arr_rdata = mem_r[bus_addr[7:0]];
endmodule // dee_array_model
`default_nettype wire

/* dv/dee_ctrl_sva.sv */
// Port-level checker for the data EEPROM controller.
// Assumes it is bound to the controller top with its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module dee_ctrl_sva #(
  parameter int unsigned PROG_CYC = 20,
  parameter int unsigned ERASE_CYC = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic bus_rd,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rdata_en_n,
  input wire logic ext_access,
  input wire logic wait_for_interrupt_instr,
  input wire logic active_halt_req,
  input wire logic halt_req,
  input wire logic readout_protect_option,
  input wire logic arr_wr,
  input wire logic arr_erase_all,
  input wire logic prog_mem_erase_all,
  input wire logic busy,
  input wire logic eeprom_wait,
  input wire logic eeprom_halted
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic win;
  // Decodes the EEPROM window.
  assign win = bus_addr[15:8] == 8'h10;
  a_busy_read_undriven: assert property (bus_rd && win && busy |=> bus_rdata_en_n)
    else $error("window read answered during programming");
  a_cell_write_busy: assert property (disable iff (rst || halt_req)
    arr_wr |-> busy)
    else $error("cell write outside a cycle");
  a_busy_holds: assert property (disable iff (rst || halt_req)
    $rose(busy) |-> busy[*8])
    else $error("busy dropped early");
  a_halt_stops: assert property (halt_req |-> ##[1:3] (eeprom_halted && !busy))
    else $error("halt not taken at once");
  a_wait_idle: assert property (wait_for_interrupt_instr && !busy && !halt_req
    |-> ##[1:3] eeprom_wait)
    else $error("idle wait not entered");
  a_wait_deferred: assert property ($rose(busy) ##[1:4]
    (wait_for_interrupt_instr || active_halt_req) |-> !eeprom_wait)
    else $error("wait entered during a cycle");
  a_prot_ext_read: assert property (ext_access && readout_protect_option
    && $past(readout_protect_option) && bus_rd && win |=> bus_rdata_en_n)
    else $error("protected read-out answered");
  a_unprotect_erase: assert property ($fell(readout_protect_option) && !busy
    |-> ##[1:3] (arr_erase_all && prog_mem_erase_all))
    else $error("no erase on protection removal");
  a_erase_timed: assert property ($rose(arr_erase_all)
    |-> (arr_erase_all && busy)[*8])
    else $error("erase not held");
  a_reset_quiet: assert property ($fell(rst)
    |-> !busy && bus_rdata_en_n && !arr_wr)
    else $error("activity right after reset");
endmodule // dee_ctrl_sva
`default_nettype wire

/* dv/dee_ctrl_tb.sv */
// Self-checking testbench for the data EEPROM controller with an array model.
// Assumes short programming and erase counts set below.
`timescale 1ns/1ps
`default_nettype none
module dee_ctrl_tb;
  localparam int unsigned PROG_CYC = 20;
  localparam int unsigned ERASE_CYC = 10;
  logic mclk = 1'b0, rst = 1'b1, bus_rd = 1'b0, bus_wr = 1'b0, ext_access = 1'b0;
  logic wait_for_interrupt_instr = 1'b0, active_halt_req = 1'b0, halt_req = 1'b0;
  logic readout_protect_option = 1'b0, bus_rdata_en_n, arr_rd, arr_wr, arr_erase_all;
  logic prog_mem_erase_all, busy, eeprom_wait, eeprom_halted;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00, bus_rdata, arr_rdata, arr_addr, arr_wdata;
  int n_mismatch = 0, num_checks = 0;
  dee_ctrl #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) i_dee_ctrl (
    .mclk(mclk), .rst(rst), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rdata_en_n(bus_rdata_en_n),
    .ext_access(ext_access), .wait_for_interrupt_instr(wait_for_interrupt_instr),
    .active_halt_req(active_halt_req), .halt_req(halt_req),
    .readout_protect_option(readout_protect_option), .arr_rdata(arr_rdata),
    .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_wdata(arr_wdata), .arr_wr(arr_wr),
    .arr_erase_all(arr_erase_all), .prog_mem_erase_all(prog_mem_erase_all), .busy(busy),
    .eeprom_wait(eeprom_wait), .eeprom_halted(eeprom_halted));
  dee_array_model i_dee_array_model (
    .mclk(mclk), .bus_addr(bus_addr), .arr_addr(arr_addr), .arr_wr(arr_wr),
    .arr_wdata(arr_wdata), .arr_erase_all(arr_erase_all), .arr_rdata(arr_rdata));
  // Free-running system clock.
  initial forever #4 mclk = ~mclk;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One-cycle write pulse, then one idle cycle.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge mclk);
    bus_wr = 1'b0;
    @(negedge mclk);
  endtask
  // One-cycle read pulse; the answer is judged in the following cycle.
  task automatic rd(input logic [15:0] a, input logic ext, input logic en_n, input logic [7:0] d);
    bus_addr = a;
    ext_access = ext;
    bus_rd = 1'b1;
    @(negedge mclk);
    bus_rd = 1'b0;
    ext_access = 1'b0;
    check(8'(bus_rdata_en_n), 8'(en_n), "drive enable");
    if (!en_n) check(bus_rdata, d, "read data");
    @(negedge mclk);
  endtask
  // Bounded wait for the busy flag to reach a level.
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 200 && busy !== lvl; i++) @(negedge mclk);
    if (busy !== lvl) begin
      n_mismatch++;
      $display("MISMATCH t=%0t busy wait timed out", $time);
      report_and_stop();
    end
  endtask
  // Starts a cycle and waits it out.
  task automatic run_cycle();
    wr(16'h0030, 8'h03);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask
  task automatic t_read_mode();
    rd(16'h0030, 1'b0, 1'b0, 8'h00);
    wr(16'h1012, 8'h00);
    rd(16'h1012, 1'b0, 1'b0, 8'hFF);
    bus_addr = 16'h1034;
    bus_rd = 1'b1;
    @(negedge mclk);
    bus_rd = 1'b0;
    check(8'(arr_rd), 8'h01, "array read strobe");
    check(arr_addr, 8'h34, "array read address");
    @(negedge mclk);
  endtask
  task automatic t_program();
    wr(16'h0030, 8'h02);
    rd(16'h0030, 1'b0, 1'b0, 8'h02);
    wr(16'h1043, 8'hF0);
    wr(16'h1043, 8'h3C);
    wr(16'h1045, 8'h55);
    rd(16'h1043, 1'b0, 1'b1, 8'h00);
    wr(16'h0030, 8'h03);
    rd(16'h0030, 1'b0, 1'b0, 8'h03);
    wr(16'h0030, 8'h01);
    rd(16'h0030, 1'b0, 1'b0, 8'h03);
    wait_busy(1'b0);
    rd(16'h0030, 1'b0, 1'b0, 8'h00);
    rd(16'h1043, 1'b0, 1'b0, 8'h30);
    rd(16'h1045, 1'b0, 1'b0, 8'h55);
    rd(16'h1044, 1'b0, 1'b0, 8'hFF);
  endtask
  task automatic t_latch_drop();
    wr(16'h0030, 8'h02);
    wr(16'h1050, 8'h00);
    wr(16'h0030, 8'h00);
    wr(16'h0030, 8'h02);
    wr(16'h1071, 8'h11);
    run_cycle();
    rd(16'h1050, 1'b0, 1'b0, 8'hFF);
    rd(16'h1071, 1'b0, 1'b0, 8'h11);
  endtask
  task automatic t_wait();
    wait_for_interrupt_instr = 1'b1;
    repeat (3) @(negedge mclk);
    check(8'(eeprom_wait), 8'h01, "idle wait");
    wait_for_interrupt_instr = 1'b0;
    repeat (3) @(negedge mclk);
    wr(16'h0030, 8'h02);
    wr(16'h1060, 8'hAA);
    wr(16'h0030, 8'h03);
    wait_busy(1'b1);
    active_halt_req = 1'b1;
    @(negedge mclk);
    check(8'(eeprom_wait), 8'h00, "deferred wait");
    wait_busy(1'b0);
    repeat (3) @(negedge mclk);
    check(8'(eeprom_wait), 8'h01, "wait after cycle");
    active_halt_req = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic t_halt_reset();
    wr(16'h0030, 8'h02);
    wr(16'h1061, 8'h00);
    wr(16'h0030, 8'h03);
    wait_busy(1'b1);
    halt_req = 1'b1;
    repeat (3) @(negedge mclk);
    check(8'({eeprom_halted, busy}), 8'h02, "halt");
    rst = 1'b1;
    halt_req = 1'b0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    rd(16'h0030, 1'b0, 1'b0, 8'h00);
  endtask
  task automatic t_protect();
    readout_protect_option = 1'b1;
    repeat (4) @(negedge mclk);
    rd(16'h1060, 1'b1, 1'b1, 8'h00);
    wr(16'h0030, 8'h02);
    wr(16'h1060, 8'h00);
    wr(16'h0030, 8'h03);
    repeat (60) @(negedge mclk);
    wr(16'h0030, 8'h00);
    rd(16'h1060, 1'b0, 1'b0, 8'hAA);
    readout_protect_option = 1'b0;
    repeat (3) @(negedge mclk);
    check(8'({arr_erase_all, prog_mem_erase_all}), 8'h03, "erase");
    wait_busy(1'b0);
    rd(16'h1060, 1'b0, 1'b0, 8'hFF);
    rd(16'h1045, 1'b0, 1'b0, 8'hFF);
  endtask
  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    t_read_mode();
    t_program();
    t_latch_drop();
    t_wait();
    t_halt_reset();
    t_protect();
    report_and_stop();
  end
endmodule // dee_ctrl_tb
bind dee_ctrl dee_ctrl_sva #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) i_dee_ctrl_sva (
  .mclk(mclk), .rst(rst), .bus_rd(bus_rd), .bus_addr(bus_addr),
  .bus_rdata_en_n(bus_rdata_en_n), .ext_access(ext_access),
  .wait_for_interrupt_instr(wait_for_interrupt_instr), .active_halt_req(active_halt_req),
  .halt_req(halt_req), .readout_protect_option(readout_protect_option), .arr_wr(arr_wr),
  .arr_erase_all(arr_erase_all), .prog_mem_erase_all(prog_mem_erase_all), .busy(busy),
  .eeprom_wait(eeprom_wait), .eeprom_halted(eeprom_halted));
`default_nettype wire
